// ---- design/prs_sequencer.sv ----
// start-up and reset sequencer of a 10/100 ethernet transceiver
`timescale 1ns/1ps
module prs_sequencer #(
   parameter logic [prs_pkg::CNT_W-1:0] MGMT_RST_LIMIT = prs_pkg::CNT_W'(prs_pkg::MGMT_RST_CYC),
   parameter logic [prs_pkg::CNT_W-1:0] MGMT_PWR_LIMIT = prs_pkg::CNT_W'(prs_pkg::MGMT_PWR_CYC),
   parameter logic [prs_pkg::CNT_W-1:0] FLP_LIMIT      = prs_pkg::CNT_W'(prs_pkg::FLP_CYC)
) (
   // clock and power-on reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // reset pin, active low
   input  wire logic                        rst_pin_n,
   // shared strap / output pins
   input  wire prs_pkg::prs_strap_s         cfg_pin_in,
   input  wire prs_pkg::prs_strap_s         func_out,
   output prs_pkg::prs_strap_s              cfg_pin_out,
   output logic [prs_pkg::STRAP_W-1:0]      cfg_pin_oe,
   // latched configuration
   output prs_pkg::prs_strap_s              strap,
   output logic                             strap_valid,
   // management bus
   input  wire prs_pkg::prs_mgmt_s          mgmt,
   output logic                             mgmt_enable,
   output logic                             preamble_det,
   output logic                             access_start,
   // core control
   output logic                             core_reset,
   output logic                             flp_enable
);
   import prs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state and sequence counter
   prs_state_e       state;
   prs_state_e       next_state;
   logic [SEQ_W-1:0] seq_cnt;
   logic [SEQ_W-1:0] next_seq_cnt;
   logic             power_up;
   logic             mdc_q;
   logic [PRE_W-1:0] ones_cnt;
   logic [PRE_W-1:0] next_ones_cnt;
   logic             mgmt_done;
   logic             flp_done;

   wire pin_low     = !rst_pin_n;
   wire seq_zero    = (seq_cnt == '0);
   wire latch_now   = (state == ST_LATCH) && seq_zero && !pin_low;
   wire drive_now   = (state == ST_DRIVE) && seq_zero && !pin_low;
   wire timer_clear = (state == ST_HOLD) || pin_low;
   wire mdc_rise    = mgmt.mdc && !mdc_q;
   wire pre_full    = (ones_cnt == PRE_LEN);
   wire pre_last    = (ones_cnt == (PRE_LEN - PRE_W'(1)));
   wire listen      = mgmt_enable && !pin_low;
   // power-up uses the longer settling window before management is trusted
   wire [CNT_W-1:0] mgmt_limit = power_up ? MGMT_PWR_LIMIT : MGMT_RST_LIMIT;

   always_comb begin
      next_state   = state;
      next_seq_cnt = seq_cnt;
      case (state)
         ST_HOLD: begin
            if (!pin_low) begin
               next_state   = ST_LATCH;
               next_seq_cnt = LATCH_LOAD;
            end
         end
         ST_LATCH: begin
            if (seq_zero) begin
               next_state   = ST_DRIVE;
               next_seq_cnt = DRIVE_LOAD;
            end else begin
               next_seq_cnt = seq_cnt - SEQ_W'(1);
            end
         end
         ST_DRIVE: begin
            if (seq_zero) begin
               next_state = ST_RUN;
            end else begin
               next_seq_cnt = seq_cnt - SEQ_W'(1);
            end
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_HOLD;
         end
      endcase
      // pin low overrides every state
      if (pin_low) begin
         next_state   = ST_HOLD;
         next_seq_cnt = '0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state   <= ST_HOLD;
         seq_cnt <= '0;
      end else begin
         state   <= next_state;
         seq_cnt <= next_seq_cnt;
      end
   end

   // first pin reset turns the power-up window into the short one
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         power_up <= 1'b1;
      end else if (pin_low) begin
         power_up <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // straps and shared pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strap       <= STRAP_RST;
         strap_valid <= 1'b0;
      end else if (pin_low) begin
         strap_valid <= 1'b0;
      end else if (latch_now) begin
         strap       <= cfg_pin_in;
         strap_valid <= 1'b1;
      end
   end

   // pins stay inputs until the straps are safely captured
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_pin_oe  <= '0;
         cfg_pin_out <= STRAP_RST;
         core_reset  <= 1'b1;
      end else begin
         cfg_pin_oe  <= (next_state == ST_RUN) ? '1 : '0;
         cfg_pin_out <= func_out;
         core_reset  <= (next_state != ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // long waits
   prs_timer u_mgmt_tmr (
      .clk   (clk),
      .reset (reset),
      .clear (timer_clear),
      .limit (mgmt_limit),
      .done  (mgmt_done)
   );

   prs_timer u_flp_tmr (
      .clk   (clk),
      .reset (reset),
      .clear (timer_clear),
      .limit (FLP_LIMIT),
      .done  (flp_done)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mgmt_enable <= 1'b0;
         flp_enable  <= 1'b0;
      end else begin
         mgmt_enable <= mgmt_done && !pin_low;
         flp_enable  <= flp_done && !pin_low && (state == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // preamble detection, sampled on mdc rising
   always_comb begin
      next_ones_cnt = ones_cnt;
      if (!listen) begin
         next_ones_cnt = '0;
      end else if (mdc_rise) begin
         if (!mgmt.mdio) begin
            next_ones_cnt = '0;
         end else if (!pre_full) begin
            next_ones_cnt = ones_cnt + PRE_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mdc_q        <= 1'b0;
         ones_cnt     <= '0;
         preamble_det <= 1'b0;
         access_start <= 1'b0;
      end else begin
         mdc_q        <= mgmt.mdc;
         ones_cnt     <= next_ones_cnt;
         preamble_det <= listen && mdc_rise && mgmt.mdio && pre_last;
         access_start <= listen && mdc_rise && !mgmt.mdio && pre_full;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   logic [15:0] since_rel;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         since_rel <= '0;
      end else if (state == ST_HOLD) begin
         since_rel <= '0;
      end else if (since_rel != 16'hFFFF) begin
         since_rel <= since_rel + 16'h0001;
      end
   end

   a_strap_latch_time: assert property (@(posedge clk) disable iff (reset)
      $rose(strap_valid) |-> since_rel == 16'(LATCH_CYC))
      else $error("straps latched at wrong time");

   a_pin_drive_time: assert property (@(posedge clk) disable iff (reset)
      $rose(cfg_pin_oe[0]) |-> since_rel == 16'(LATCH_CYC + DRIVE_CYC) && strap_valid)
      else $error("pins driven at wrong time");

   a_hold_in_reset: assert property (@(posedge clk) disable iff (reset)
      pin_low |=> state == ST_HOLD && cfg_pin_oe == '0 && core_reset && !mgmt_enable
                  && !preamble_det && !flp_enable)
      else $error("activity while reset pin low");

   a_preamble_count: assert property (@(posedge clk) disable iff (reset)
      preamble_det |-> $past(ones_cnt) == PRE_LEN - PRE_W'(1) && $past(mgmt_enable)
                      && ones_cnt == PRE_LEN)
      else $error("preamble flagged without 32 ones");

   a_start_after_pre: assert property (@(posedge clk) disable iff (reset)
      access_start |-> $past(ones_cnt) == PRE_LEN && ones_cnt == '0)
      else $error("access start without full preamble");

   a_mgmt_wait_done: assert property (@(posedge clk) disable iff (reset)
      $rose(mgmt_enable) |-> $past(mgmt_done) && !$past(pin_low))
      else $error("management enabled before wait");

   a_flp_after_wait: assert property (@(posedge clk) disable iff (reset)
      $rose(flp_enable) |-> $past(flp_done) && !cfg_pin_oe[0] == 1'b0 && !core_reset)
      else $error("link pulses started early");

   a_pins_inputs_early: assert property (@(posedge clk) disable iff (reset)
      !strap_valid |-> cfg_pin_oe == '0)
      else $error("pins driven before straps latched");

   c_release_run: cover property (@(posedge clk) disable iff (reset)
      $rose(cfg_pin_oe[0]));
   c_preamble_seen: cover property (@(posedge clk) disable iff (reset)
      preamble_det ##[1:200] access_start);
   c_pin_reset_run: cover property (@(posedge clk) disable iff (reset)
      pin_low ##1 !pin_low ##[1:30] state == ST_RUN);

endmodule

// ---- pkg/prs_pkg.sv ----
// shared constants, types and timing counts of the phy reset sequencer
package prs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and widths
   localparam int CLK_PERIOD_NS = 10;
   localparam int STRAP_W       = 4;
   localparam int CNT_W         = 28;
   localparam int SEQ_W         = 4;
   localparam int PRE_W         = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // times in their own units
   localparam int  T_LATCH_NS    = 120;
   localparam int  T_DRIVE_NS    = 64;
   localparam int  T_MGMT_RST_MS = 2;
   localparam int  T_MGMT_PWR_MS = 200;
   localparam real T_FLP_S       = 1.5;

   ////////////////////////////////////////////////////////////////////////////////
   // derived cycle counts: short waits round up, longest waits round down
   localparam int LATCH_CYC    = (T_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRIVE_CYC    = (T_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MGMT_RST_CYC = (T_MGMT_RST_MS * 1000000) / CLK_PERIOD_NS;
   localparam int MGMT_PWR_CYC = (T_MGMT_PWR_MS * 1000000) / CLK_PERIOD_NS;
   localparam int FLP_CYC      = int'(T_FLP_S * 1.0e9) / CLK_PERIOD_NS;

   localparam logic [SEQ_W-1:0] LATCH_LOAD = SEQ_W'(LATCH_CYC - 1);
   localparam logic [SEQ_W-1:0] DRIVE_LOAD = SEQ_W'(DRIVE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // management preamble
   localparam logic [PRE_W-1:0] PRE_LEN = 6'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ST_HOLD  = 2'b00,
      ST_LATCH = 2'b01,
      ST_DRIVE = 2'b10,
      ST_RUN   = 2'b11
   } prs_state_e;

   typedef struct packed {
      logic [STRAP_W-1:0] level;
   } prs_strap_s;

   typedef struct packed {
      logic mdc;
      logic mdio;
   } prs_mgmt_s;

endpackage

// ---- design/prs_timer.sv ----
// elapsed-time counter used for the long start-up waits
`timescale 1ns/1ps
module prs_timer (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // control
   input  wire logic                      clear,
   input  wire logic [prs_pkg::CNT_W-1:0] limit,
   // status
   output logic                           done
);
   import prs_pkg::*;

   logic [CNT_W-1:0] count;
   wire              at_end;

   // limit must be at least one cycle
   assign at_end = (count == (limit - CNT_W'(1)));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         done  <= 1'b0;
      end else if (clear) begin
         count <= '0;
         done  <= 1'b0;
      end else if (!done) begin
         count <= count + CNT_W'(1);
         done  <= at_end;
      end
   end

   a_timer_cleared: assert property (@(posedge clk) disable iff (reset)
      clear |=> !done)
      else $error("timer done while cleared");

endmodule

// ---- dv/prs_station.sv ----
// reset controller and management station model facing the sequencer
`timescale 1ns/1ps
module prs_station (
   // clock
   input  wire logic          clk,
   // reset pin and management bus
   output logic               rst_pin_n,
   output prs_pkg::prs_mgmt_s mgmt
);
   import prs_pkg::*;
   int up_cyc = 0;
   initial begin
      rst_pin_n = 1'h1;
      mgmt      = '{mdc: 1'h0, mdio: 1'h1};
   end
   always @(posedge clk) up_cyc <= up_cyc + 1;
   ////////////////////////////////////////////////////////////////////////////////
   // below 1000 cycles is only a deliberate short pulse
   task automatic hold_reset(input int cyc);
      wait (up_cyc >= 100);
      @(negedge clk) rst_pin_n = 1'h0;
      repeat (cyc) @(negedge clk);
      rst_pin_n = 1'h1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // mdc high and low one cycle each; idle mdio rests at the pull-up level
   task automatic send_bit(input logic b);
      @(negedge clk);
      mgmt.mdc  = 1'h0;
      mgmt.mdio = b;
      @(negedge clk) mgmt.mdc = 1'h1;
   endtask
   task automatic send_frame(input int ones, input logic zero);
      repeat (ones) send_bit(1'h1);
      if (zero) send_bit(1'h0);
      @(negedge clk);
      mgmt.mdc  = 1'h0;
      mgmt.mdio = 1'h1;
   endtask
endmodule

// ---- dv/prs_sequencer_tb.sv ----
// self-checking bench of the start-up and reset sequencer
`timescale 1ns/1ps
module prs_sequencer_tb;
   import prs_pkg::*;
   localparam int RST_LIM   = 50;
   localparam int PWR_LIM   = 80;
   localparam int FLP_LIM   = 120;
   localparam int STRAP_DLY = LATCH_CYC + 1;
   localparam int DRIVE_DLY = STRAP_DLY + DRIVE_CYC;
   logic       clk = 1'h0;
   logic       reset = 1'h1;
   logic       rst_pin_n;
   prs_strap_s cfg_pin_in = '{level: 4'hA};
   prs_strap_s func_out = '{level: 4'h6};
   prs_strap_s cfg_pin_out;
   logic [3:0] cfg_pin_oe;
   prs_strap_s strap;
   logic       strap_valid;
   prs_mgmt_s  mgmt;
   logic       mgmt_enable;
   logic       preamble_det;
   logic       access_start;
   logic       core_reset;
   logic       flp_enable;
   int         bad_count = 0;
   int         checks = 0;
   int         pre_n = 0;
   int         acc_n = 0;

   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (preamble_det === 1'h1) pre_n <= pre_n + 1;
      if (access_start === 1'h1) acc_n <= acc_n + 1;
   end

   prs_station prs_station_i (.clk(clk), .rst_pin_n(rst_pin_n), .mgmt(mgmt));
   prs_sequencer #(
      .MGMT_RST_LIMIT(CNT_W'(RST_LIM)),
      .MGMT_PWR_LIMIT(CNT_W'(PWR_LIM)),
      .FLP_LIMIT     (CNT_W'(FLP_LIM))
   ) prs_sequencer_i (
      .clk(clk), .reset(reset), .rst_pin_n(rst_pin_n), .cfg_pin_in(cfg_pin_in),
      .func_out(func_out), .cfg_pin_out(cfg_pin_out), .cfg_pin_oe(cfg_pin_oe),
      .strap(strap), .strap_valid(strap_valid), .mgmt(mgmt),
      .mgmt_enable(mgmt_enable), .preamble_det(preamble_det),
      .access_start(access_start), .core_reset(core_reset), .flp_enable(flp_enable)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   task automatic results;
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // follow one start sequence from release and time each stage
   task automatic measure(input logic [3:0] sv, input int lim);
      int t_s = 0;
      int t_o = 0;
      int t_m = 0;
      int t_f = 0;
      for (int n = 1; n <= FLP_LIM + 20; n++) begin
         @(negedge clk);
         if (t_s == 0 && strap_valid === 1'h1) t_s = n;
         if (t_o == 0 && cfg_pin_oe !== 4'h0) begin
            t_o = n;
            cmp("oe", 32'hF, cfg_pin_oe);
            cmp("core_reset", 32'h0, core_reset);
         end
         if (t_m == 0 && mgmt_enable === 1'h1) t_m = n;
         if (t_f == 0 && flp_enable === 1'h1) t_f = n;
      end
      cmp("strap delay", STRAP_DLY, t_s);
      cmp("strap", sv, strap.level);
      cmp("drive delay", DRIVE_DLY, t_o);
      rng("mgmt delay", lim, lim + 4, t_m);
      rng("flp delay", FLP_LIM, FLP_LIM + 4, t_f);
      cmp("pin out", func_out.level, cfg_pin_out.level);
      cfg_pin_in.level = ~sv;
      repeat (3) @(negedge clk);
      cmp("strap held", sv, strap.level);
   endtask
   // 31 ones are no preamble; 33 ones give one preamble and one start
   task automatic t_preamble;
      int p0;
      int a0;
      p0 = pre_n;
      a0 = acc_n;
      prs_station_i.send_frame(31, 1'h1);
      // the pulse counters move two rising clock edges after the last mdc rise
      @(negedge clk);
      cmp("short pre", p0, pre_n);
      cmp("short acc", a0, acc_n);
      prs_station_i.send_frame(33, 1'h1);
      @(negedge clk);
      cmp("pre", p0 + 1, pre_n);
      cmp("acc", a0 + 1, acc_n);
   endtask
   // everything held and management ignored while the pin is low
   task automatic t_pin_reset;
      int p0;
      int a0;
      p0 = pre_n;
      a0 = acc_n;
      cfg_pin_in.level = 4'h5;
      fork
         prs_station_i.hold_reset(1000);
         begin
            repeat (20) @(negedge clk);
            prs_station_i.send_frame(40, 1'h1);
            @(negedge clk);
            cmp("low pre", p0, pre_n);
            cmp("low acc", a0, acc_n);
            cmp("low oe", 32'h0, cfg_pin_oe);
            cmp("low core", 32'h1, core_reset);
            cmp("low valid", 32'h0, strap_valid);
            cmp("low mgmt", 32'h0, mgmt_enable);
            cmp("low flp", 32'h0, flp_enable);
         end
      join
      measure(4'h5, RST_LIM);
      t_preamble();
   endtask
   // a short pulse in mid-sequence restarts it from the start
   task automatic t_abort;
      prs_station_i.hold_reset(1000);
      cfg_pin_in.level = 4'hC;
      repeat (8) @(negedge clk);
      cfg_pin_in.level = 4'h3;
      prs_station_i.hold_reset(3);
      cmp("abort valid", 32'h0, strap_valid);
      measure(4'h3, RST_LIM);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge clk);
      reset = 1'h0;
      measure(4'hA, PWR_LIM);
      t_preamble();
      t_pin_reset();
      t_abort();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      results();
   end
endmodule
